// ### hw/pild_pkg.sv
// ============================================================
// Shared constants for the port input and immediate load decoder
package pild_pkg;
  // Instruction word and data widths
  localparam int unsigned INSTR_W = 10;
  localparam int unsigned NIB_W = 4;
  // Fixed opcodes
  localparam logic [9:0] OP_PORT_TWO = 10'h262;
  localparam logic [9:0] OP_INC_DIGIT = 10'h013;
  // Prefixes of the immediate forms
  localparam logic [5:0] PFX_LOAD_ACC = 6'h07;
  localparam logic [1:0] PFX_LOAD_PTRS = 2'h3;
  // Field positions
  localparam int unsigned IMM_LSB = 0;
  localparam int unsigned FILE_LSB = 4;
  localparam int unsigned DIGIT_LSB = 0;
  // Values after reset
  localparam logic [3:0] ACC_RST = 4'h0;
  localparam logic [3:0] FILE_RST = 4'h0;
  localparam logic [3:0] DIGIT_RST = 4'h0;
  // Synchroniser depth for the input port
  localparam int unsigned SYNC_STAGES = 2;
  // Instruction classes, one-hot
  typedef enum logic [4:0] {
    PILD_CLS_OTHER = 5'b00001,
    PILD_CLS_PORT = 5'b00010,
    PILD_CLS_INC = 5'b00100,
    PILD_CLS_LDA = 5'b01000,
    PILD_CLS_LDP = 5'b10000
  } pild_cls_t;
endpackage : pild_pkg

// ### hw/pild_sync.sv
`timescale 1ns/1ps
`default_nettype none
// ============================================================
// Two-stage synchroniser for a nibble-wide input port
module pild_sync
  import pild_pkg::*;
(
  // Clock and reset
  input wire logic core_clk_i,
  input wire logic resetn_i,
  // Asynchronous nibble in, synchronised nibble out
  input wire logic [3:0] async_i,
  output logic [3:0] sync_o
);
  // Both stages held in one struct; first stage feeds only the second
  typedef struct packed {
    logic [3:0] meta;
    logic [3:0] stable;
  } pild_sync_st_t;
  pild_sync_st_t st_r;
  pild_sync_st_t st_nxt;

  // ============================================================
  // Next value
  always_comb
  begin
    st_nxt.meta = async_i;
    st_nxt.stable = st_r.meta;
  end

  // ============================================================
  // Registers, cleared to zero so the port reads a defined level
  always_ff @(posedge core_clk_i)
  begin
    if (!resetn_i)
      st_r <= '0;
    else
      st_r <= st_nxt;
  end

  assign sync_o = st_r.stable;
endmodule : pild_sync
`default_nettype wire

// ### hw/pild_core.sv
`timescale 1ns/1ps
`default_nettype none
module pild_core
  import pild_pkg::*;
(
  // Clock and reset
  input wire logic core_clk_i,
  input wire logic resetn_i,
  // Instruction stream, one word per machine cycle
  input wire logic instr_valid_i,
  input wire logic [pild_pkg::INSTR_W-1:0] instr_i,
  // Third input port pins, asynchronous
  input wire logic [pild_pkg::NIB_W-1:0] third_input_port_i,
  // Architectural registers
  output logic [pild_pkg::NIB_W-1:0] acc_o,
  output logic [pild_pkg::NIB_W-1:0] file_ptr_o,
  output logic [pild_pkg::NIB_W-1:0] digit_ptr_o,
  // Per-cycle status of the last word taken
  output logic done_o,
  output logic skipped_o,
  output logic pc_inc_o
);
  import pild_pkg::*;

  // ============================================================
  // Instruction classifier, used by the datapath and the checks
  function automatic pild_cls_t pild_classify(input logic [9:0] w);
    pild_cls_t c;
    c = PILD_CLS_OTHER;
    if (w == OP_PORT_TWO)
      c = PILD_CLS_PORT;
    else if (w == OP_INC_DIGIT)
      c = PILD_CLS_INC;
    else if (w[9:4] == PFX_LOAD_ACC)
      c = PILD_CLS_LDA;
    else if (w[9:8] == PFX_LOAD_PTRS)
      c = PILD_CLS_LDP;
    return c;
  endfunction : pild_classify

  // ============================================================
  // State of the block
  typedef struct packed {
    logic [3:0] acc; // Accumulator
    logic [3:0] fptr; // File pointer
    logic [3:0] dptr; // Digit pointer
    logic skip_pend; // Next word is to be skipped
    pild_cls_t prev; // Class of the previous word taken
    logic done; // Pulse: a word was taken
    logic skipped; // Pulse: that word was skipped
  } pild_st_t;
  pild_st_t st_r;
  pild_st_t st_nxt;

  logic [3:0] port_sync; // Synchronised port levels
  pild_cls_t cls; // Class of the current word
  logic skip_now; // Current word is suppressed
  logic [3:0] dptr_inc; // Incremented digit pointer

  // ============================================================
  // Port pins come from outside the clock domain
  pild_sync u_sync (
    .core_clk_i(core_clk_i),
    .resetn_i(resetn_i),
    .async_i(third_input_port_i),
    .sync_o(port_sync)
  );

  assign cls = pild_classify(instr_i);
  assign dptr_inc = 4'(st_r.dptr + 4'h1);
  // Suppressed by a pending zero skip or by an unbroken load run
  assign skip_now = st_r.skip_pend
    || (cls == PILD_CLS_LDA && st_r.prev == PILD_CLS_LDA)
    || (cls == PILD_CLS_LDP && st_r.prev == PILD_CLS_LDP);

  // ============================================================
  // Execute one word per valid cycle
  always_comb
  begin
    st_nxt = st_r;
    st_nxt.done = 1'b0;
    st_nxt.skipped = 1'b0;
    if (instr_valid_i)
    begin
      // Run tracking counts skipped words too, so a run stays unbroken
      st_nxt.prev = cls;
      st_nxt.done = 1'b1;
      st_nxt.skip_pend = 1'b0;
      if (skip_now)
      begin
        // No-op: nothing changes but the program counter
        st_nxt.skipped = 1'b1;
      end
      else
      begin
        unique case (cls)
          PILD_CLS_PORT: st_nxt.acc = port_sync;
          PILD_CLS_INC:
          begin
            st_nxt.dptr = dptr_inc;
            st_nxt.skip_pend = (dptr_inc == 4'h0);
          end
          PILD_CLS_LDA: st_nxt.acc = instr_i[IMM_LSB +: 4];
          PILD_CLS_LDP:
          begin
            st_nxt.fptr = instr_i[FILE_LSB +: 4];
            st_nxt.dptr = instr_i[DIGIT_LSB +: 4];
          end
          PILD_CLS_OTHER: st_nxt.acc = st_r.acc;
        endcase
      end
    end
  end

  // ============================================================
  // State register
  always_ff @(posedge core_clk_i)
  begin
    if (!resetn_i)
    begin
      st_r.acc <= ACC_RST;
      st_r.fptr <= FILE_RST;
      st_r.dptr <= DIGIT_RST;
      st_r.skip_pend <= 1'b0;
      st_r.prev <= PILD_CLS_OTHER;
      st_r.done <= 1'b0;
      st_r.skipped <= 1'b0;
    end
    else
      st_r <= st_nxt;
  end

  // Outputs straight from flops
  assign acc_o = st_r.acc;
  assign file_ptr_o = st_r.fptr;
  assign digit_ptr_o = st_r.dptr;
  assign done_o = st_r.done;
  assign skipped_o = st_r.skipped;
  // Every word, executed or skipped, advances the count by one
  assign pc_inc_o = st_r.done;

  // ============================================================
  // Checks
  port_load_a: assert property (@(posedge core_clk_i) disable iff (!resetn_i)
    instr_valid_i && cls == PILD_CLS_PORT && !skip_now |=> acc_o == $past(port_sync))
    else $error("port read did not reach accumulator");

  inc_value_a: assert property (@(posedge core_clk_i) disable iff (!resetn_i)
    instr_valid_i && cls == PILD_CLS_INC && !skip_now |=> digit_ptr_o == 4'($past(st_r.dptr) + 4'h1))
    else $error("digit pointer not incremented");

  // A wrap to zero arms the skip flag; the next word taken is then dropped
  inc_skip_a: assert property (@(posedge core_clk_i) disable iff (!resetn_i)
    instr_valid_i && cls == PILD_CLS_INC && !skip_now && st_r.dptr == 4'hf |=> st_r.skip_pend)
    else $error("zero wrap did not arm the skip");

  skip_apply_a: assert property (@(posedge core_clk_i) disable iff (!resetn_i)
    st_r.skip_pend && instr_valid_i |=> skipped_o && !st_r.skip_pend)
    else $error("pending skip was not applied to the next word");

  // Idle cycles must not lose the pending skip, or a stalled fetch would run the word
  skip_hold_a: assert property (@(posedge core_clk_i) disable iff (!resetn_i)
    st_r.skip_pend && !instr_valid_i |=> st_r.skip_pend)
    else $error("pending skip lost in an idle cycle");

  inc_noskip_a: assert property (@(posedge core_clk_i) disable iff (!resetn_i)
    instr_valid_i && cls == PILD_CLS_INC && !skip_now && st_r.dptr != 4'hf |=> !st_r.skip_pend)
    else $error("skip armed without zero result");

  lda_load_a: assert property (@(posedge core_clk_i) disable iff (!resetn_i)
    instr_valid_i && cls == PILD_CLS_LDA && !skip_now |=> acc_o == $past(instr_i[3:0]))
    else $error("immediate not loaded into accumulator");

  lda_run_a: assert property (@(posedge core_clk_i) disable iff (!resetn_i)
    instr_valid_i && cls == PILD_CLS_LDA && st_r.prev == PILD_CLS_LDA |=> skipped_o && $stable(acc_o))
    else $error("repeated accumulator load took effect");

  // First load of a run must act, else a lone load would be lost
  lda_first_a: assert property (@(posedge core_clk_i) disable iff (!resetn_i)
    instr_valid_i && cls == PILD_CLS_LDA && st_r.prev != PILD_CLS_LDA && !st_r.skip_pend |=> !skipped_o)
    else $error("first accumulator load of a run was skipped");

  ldp_load_a: assert property (@(posedge core_clk_i) disable iff (!resetn_i)
    instr_valid_i && cls == PILD_CLS_LDP && !skip_now
    |=> file_ptr_o == $past(instr_i[7:4]) && digit_ptr_o == $past(instr_i[3:0]))
    else $error("pointer immediates not loaded");

  ldp_run_a: assert property (@(posedge core_clk_i) disable iff (!resetn_i)
    instr_valid_i && cls == PILD_CLS_LDP && st_r.prev == PILD_CLS_LDP
    |=> skipped_o && $stable(file_ptr_o) && $stable(digit_ptr_o))
    else $error("repeated pointer load took effect");

  // First pointer load of a run must act as well
  ldp_first_a: assert property (@(posedge core_clk_i) disable iff (!resetn_i)
    instr_valid_i && cls == PILD_CLS_LDP && st_r.prev != PILD_CLS_LDP && !st_r.skip_pend |=> !skipped_o)
    else $error("first pointer load of a run was skipped");

  skip_nop_a: assert property (@(posedge core_clk_i) disable iff (!resetn_i)
    skipped_o |-> pc_inc_o && $stable(acc_o) && $stable(file_ptr_o))
    else $error("skipped word changed state or stalled");

  skip_digit_a: assert property (@(posedge core_clk_i) disable iff (!resetn_i)
    skipped_o |-> $stable(digit_ptr_o))
    else $error("skipped word changed the digit pointer");

  lda_run_c: cover property (@(posedge core_clk_i) disable iff (!resetn_i)
    instr_valid_i && cls == PILD_CLS_LDA ##1 instr_valid_i && cls == PILD_CLS_LDA);
  ldp_run_c: cover property (@(posedge core_clk_i) disable iff (!resetn_i)
    instr_valid_i && cls == PILD_CLS_LDP ##1 instr_valid_i && cls == PILD_CLS_LDP);
  wrap_skip_c: cover property (@(posedge core_clk_i) disable iff (!resetn_i)
    st_r.skip_pend && instr_valid_i);
  port_read_c: cover property (@(posedge core_clk_i) disable iff (!resetn_i)
    instr_valid_i && cls == PILD_CLS_PORT && !skip_now);
  inc_step_c: cover property (@(posedge core_clk_i) disable iff (!resetn_i)
    instr_valid_i && cls == PILD_CLS_INC && !skip_now);
endmodule : pild_core
`default_nettype wire

// ### tb/tb.sv
`timescale 1ns/1ps
`default_nettype none
// ============================================================
// Self-checking bench for the port input and immediate load decoder
module tb;
  import pild_pkg::*;
  // Stimulus and observed signals
  logic core_clk_i = 1'b0;
  logic resetn_i = 1'b0;
  logic instr_valid_i = 1'b0;
  logic [9:0] instr_i = 10'h000;
  logic [3:0] port_pins = 4'h9;
  logic [3:0] acc, file_ptr, digit_ptr;
  logic done, skipped, pc_inc;
  int n_fail = 0;
  int num_checks = 0;
  // Status packed as done, skipped, pc advance
  localparam logic [3:0] ST_RUN = 4'h5;
  localparam logic [3:0] ST_SKIP = 4'h7;
  localparam logic [3:0] ST_IDLE = 4'h0;
  // ============================================================
  // Clock at 125 MHz
  always #4 core_clk_i = ~core_clk_i;
  // ============================================================
  // Device under test
  pild_core u_pild_core (
    .core_clk_i(core_clk_i),
    .resetn_i(resetn_i),
    .instr_valid_i(instr_valid_i),
    .instr_i(instr_i),
    .third_input_port_i(port_pins),
    .acc_o(acc),
    .file_ptr_o(file_ptr),
    .digit_ptr_o(digit_ptr),
    .done_o(done),
    .skipped_o(skipped),
    .pc_inc_o(pc_inc)
  );
  // ============================================================
  // Shared helpers
  // Compare one value with its expectation
  task check(input logic [3:0] seen, input logic [3:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("Error t=%0t seen %h exp %h", $time, seen, exp);
    end
  endtask : check
  // Present a word just after the edge, taken at the next one; after it, outputs show the word of the previous step
  task step(input logic [9:0] w, input logic v);
    @(posedge core_clk_i);
    instr_i <= w;
    instr_valid_i <= v;
    #1;
  endtask : step
  // Status flags of the last word taken
  task st(input logic [3:0] exp);
    check({1'b0, done, skipped, pc_inc}, exp);
  endtask : st
  // Verdict and end of run
  task stop_test;
    $display("Checks %0d, mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : stop_test
  // ============================================================
  // Scenarios
  // Port read, twice with different pin levels; pins settle past the synchroniser
  task t_port;
    logic [3:0] vals [2];
    vals = '{4'h9, 4'h6};
    for (int i = 0; i < 2; i++)
    begin
      port_pins <= vals[i];
      repeat (3) step(10'h000, 1'b0);
      step(OP_PORT_TWO, 1'b1);
      step(10'h000, 1'b0);
      check(acc, vals[i]);
      st(ST_RUN);
    end
  endtask : t_port
  // Back-to-back accumulator loads: first acts, the rest are no-ops
  task t_lda;
    step(10'h075, 1'b1);
    step(10'h073, 1'b1);
    check(acc, 4'h5);
    st(ST_RUN);
    step(10'h07a, 1'b1);
    st(ST_SKIP);
    step(10'h000, 1'b1);
    check(acc, 4'h5);
    st(ST_SKIP);
    step(10'h07f, 1'b1);
    st(ST_RUN);
    step(10'h000, 1'b0);
    check(acc, 4'hf);
  endtask : t_lda
  // Back-to-back pointer loads: second leaves both pointers alone
  task t_ldp;
    step(10'h3ab, 1'b1);
    step(10'h312, 1'b1);
    check(file_ptr, 4'ha);
    check(digit_ptr, 4'hb);
    step(10'h000, 1'b1);
    check(file_ptr, 4'ha);
    check(digit_ptr, 4'hb);
    st(ST_SKIP);
    step(10'h000, 1'b0);
  endtask : t_ldp
  // Digit increment wrapping to zero skips the next word; non-zero does not
  task t_iny;
    step(10'h30f, 1'b1);
    step(OP_INC_DIGIT, 1'b1);
    check(digit_ptr, 4'hf);
    step(10'h071, 1'b1);
    check(digit_ptr, 4'h0);
    st(ST_RUN);
    step(OP_INC_DIGIT, 1'b1);
    check(acc, 4'hf);
    st(ST_SKIP);
    step(10'h07e, 1'b1);
    check(digit_ptr, 4'h1);
    st(ST_RUN);
    step(10'h000, 1'b0);
    check(acc, 4'he);
    st(ST_RUN);
    step(10'h000, 1'b0);
    st(ST_IDLE);
  endtask : t_iny
  // Reset in mid-run clears a pending skip; the first word after release acts
  task t_reset;
    step(10'h30f, 1'b1);
    step(OP_INC_DIGIT, 1'b1);
    step(10'h000, 1'b0);
    check(digit_ptr, 4'h0);
    @(posedge core_clk_i);
    resetn_i <= 1'b0;
    repeat (3) step(10'h000, 1'b0);
    check(acc, ACC_RST);
    check(digit_ptr, DIGIT_RST);
    st(ST_IDLE);
    @(posedge core_clk_i);
    resetn_i <= 1'b1;
    instr_i <= 10'h07c;
    instr_valid_i <= 1'b1;
    step(10'h000, 1'b0);
    check(acc, 4'hc);
    st(ST_RUN);
  endtask : t_reset
  // ============================================================
  // Main sequence
  initial
  begin
    repeat (12) @(posedge core_clk_i);
    resetn_i <= 1'b1;
    step(10'h000, 1'b0);
    check(acc, ACC_RST);
    check(file_ptr, FILE_RST);
    check(digit_ptr, DIGIT_RST);
    st(ST_IDLE);
    t_port();
    t_lda();
    t_ldp();
    t_iny();
    t_reset();
    stop_test();
  end
endmodule : tb
`default_nettype wire
